/* File: src/osfm_pkg.sv */
/*
  osfm_pkg: register map, field positions, source and mode codes, state type
  and default counts of the clock select and fail-safe monitor block.
  Assumes nothing of its surroundings.
*/
package osfm_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_IEN  = 8'h0C;
  // field positions
  localparam int CTRL_NEW_DIVIDER_SELECT_LSB = 0;
  localparam int CTRL_NEW_SOURCE_SELECT_LSB = 8;
  localparam int STAT_SRC_LSB  = 0;
  localparam int STAT_DIV_LSB  = 4;
  localparam int STAT_FAIL_BIT = 12;
  localparam int STAT_OST_BIT  = 13;
  localparam int STAT_SAMP_BIT = 14;
  localparam int STAT_MON_BIT  = 15;
  localparam int STAT_RST_LSB  = 16;
  localparam int STAT_EXT_LSB  = 20;
  localparam int FLAG_FAIL_BIT = 0;
  localparam int IEN_FAIL_BIT  = 0;
  localparam int IEN_GLOB_BIT  = 1;
  // clock source codes
  localparam logic [2:0] SRC_HF32 = 3'h0;
  localparam logic [2:0] SRC_PLL  = 3'h1;
  localparam logic [2:0] SRC_EXT  = 3'h2;
  localparam logic [2:0] SRC_SOSC = 3'h4;
  localparam logic [2:0] SRC_LF   = 3'h5;
  localparam logic [2:0] SRC_HF1  = 3'h6;
  // external mode codes
  localparam logic [2:0] EXT_HIGH = 3'h0;
  localparam logic [2:0] EXT_MED  = 3'h1;
  localparam logic [2:0] EXT_LOW  = 3'h2;
  localparam logic [2:0] XTAL_LP  = 3'h4;
  localparam logic [2:0] XTAL_XT  = 3'h5;
  localparam logic [2:0] XTAL_HS  = 3'h6;
  // power and gain codes: 0 low, 1 medium, 2 high
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MED  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // reset values, oscillator frequencies and default counts
  localparam logic [4:0] NEW_DIVIDER_SELECT_ONE      = 5'h00;
  localparam logic [2:0] SRC_RST       = SRC_HF1;
  localparam int         LF_FREQ_KHZ   = 31;
  localparam int         HF_MIN_MHZ    = 1;
  localparam int         HF_MAX_MHZ    = 32;
  localparam int         SAMPLE_DIV_DEF = 64;
  localparam int         OST_CYCLES_DEF = 1024;
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_START = 3'b010,
    ST_FAIL  = 3'b100
  } osfm_state_t;
endpackage : osfm_pkg

/* File: src/osfm_mon_if.sv */
/*
  osfm_mon_if: events between the clock selector and its fail detector.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface osfm_mon_if;
  logic lf_rise;
  logic ext_fall;
  logic mon_en;
  logic fail_pulse;
  logic sample_clk;
  modport mon (input lf_rise, input ext_fall, input mon_en,
               output fail_pulse, output sample_clk);
  modport ctl (output lf_rise, output ext_fall, output mon_en,
               input fail_pulse, input sample_clk);
endinterface : osfm_mon_if
`default_nettype wire

/* File: src/osfm_detect.sv */
/*
  osfm_detect: sample clock divider and fail latch of the clock monitor.
  Assumes edge pulses arrive already synchronised to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module osfm_detect
  import osfm_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_DEF
) (
  input  wire logic pclk,
  input  wire logic presetn,
  osfm_mon_if.mon   bus
);
  localparam int HALF = SAMPLE_DIV / 2;
  localparam int CW   = $clog2(HALF);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] div_cnt_r;
  logic          samp_r;
  logic          latch_r;
  logic          armed_r;
  logic          wrap;
  logic          samp_rise;
  logic          samp_fall;

  assign wrap      = bus.lf_rise && (div_cnt_r == LAST);
  assign samp_rise = wrap && !samp_r;
  assign samp_fall = wrap && samp_r;

  // toggles every half of the divide ratio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= '0;
      samp_r    <= 1'b0;
    end else if (bus.lf_rise) begin
      div_cnt_r <= wrap ? '0 : div_cnt_r + 1'b1;
      if (wrap) samp_r <= ~samp_r;
    end
  end

  // set wins, so a falling edge on the clearing cycle still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= 1'b0;
    end else if (bus.ext_fall) begin
      latch_r <= 1'b1;
    end else if (samp_rise) begin
      latch_r <= 1'b0;
    end
  end

  // a whole half period is only seen after a rising edge while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (!bus.mon_en) begin
      armed_r <= 1'b0;
    end else if (samp_rise) begin
      armed_r <= 1'b1;
    end
  end

  assign bus.fail_pulse = bus.mon_en && armed_r && samp_fall && !latch_r && !bus.ext_fall;
  assign bus.sample_clk = samp_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_latch_set: assert property (bus.ext_fall |=> latch_r)
    else $error("fail latch not set by external falling edge");
  a_samp_period: assert property (bus.lf_rise && !wrap |=> $stable(samp_r))
    else $error("sample clock toggled early");
  a_samp_toggle: assert property (wrap |=> samp_r != $past(samp_r))
    else $error("sample clock missed its toggle");
  a_fail_empty: assert property (bus.fail_pulse |-> !latch_r && samp_r)
    else $error("failure declared with latch set");
endmodule : osfm_detect
`default_nettype wire

/* File: src/osfm_top.sv */
/*
  osfm_top: system clock source selection, start-up timer and fail-safe
  monitor, with an apb register slave.
  Assumes straps are stable around reset release and that clock pins and the
  low-frequency oscillator are slower than a quarter of pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module osfm_top
  import osfm_pkg::*;
#(
  parameter int OST_CYCLES = OST_CYCLES_DEF,
  parameter int SAMPLE_DIV = SAMPLE_DIV_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  reset_osc_select,
  input  wire logic [2:0]  ext_osc_mode_select,
  input  wire logic        monitor_config_enable,
  input  wire logic        osc_in_pin,
  input  wire logic        sosc_in_pin,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        sleep_req,
  output logic      [2:0]  clk_src_sel,
  output logic      [4:0]  clk_div_sel,
  output logic             hf_set_32m,
  output logic      [1:0]  ext_power_sel,
  output logic      [1:0]  xtal_gain_sel,
  output logic             xtal_amp_en,
  output logic             osc_out_free,
  output logic             fail_active,
  output logic             irq_req
);
  localparam int OW = $clog2(OST_CYCLES + 1);
  localparam logic [OW-1:0] OST_LAST = OW'(OST_CYCLES - 1);

  osfm_mon_if  mon ();
  osfm_state_t state_r;
  osfm_state_t state_nxt;
  logic [2:0]  new_source_select_r;
  logic [4:0]  new_divider_select_r;
  logic [2:0]  src_r;
  logic [2:0]  src_nxt;
  logic [4:0]  div_r;
  logic [4:0]  div_nxt;
  logic [OW-1:0] ost_cnt_r;
  logic        cfg_done_r;
  logic [2:0]  rst_src_r;
  logic [2:0]  ext_mode_r;
  logic        mon_cfg_r;
  logic        flag_r;
  logic        fail_ie_r;
  logic        glob_ie_r;
  logic [2:0]  pin_raw;
  logic [2:0]  pin_fall;
  logic [2:0]  pin_rise;
  logic        wr_acc;
  logic        rd_setup;
  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_flag;
  logic        ctrl_chg;
  logic        do_sw;
  logic [2:0]  tgt_src;
  logic [4:0]  tgt_div;
  logic [2:0]  watch_src;
  logic        ext_fall;
  logic        ost_done;
  logic        fail_set;

  function automatic logic is_ext(input logic [2:0] s);
    return (s == SRC_EXT) || (s == SRC_PLL) || (s == SRC_SOSC);
  endfunction : is_ext

  function automatic logic is_ec(input logic [2:0] m);
    return (m == EXT_HIGH) || (m == EXT_MED) || (m == EXT_LOW);
  endfunction : is_ec

  // crystals need settling; the secondary oscillator is always a crystal
  function automatic logic needs_ost(input logic [2:0] s, input logic [2:0] m);
    return (s == SRC_SOSC) || (is_ext(s) && !is_ec(m));
  endfunction : needs_ost

  function automatic logic [2:0] legal_src(input logic [2:0] s);
    unique case (s)
      SRC_HF32, SRC_PLL, SRC_EXT, SRC_SOSC, SRC_LF, SRC_HF1: return s;
      default: return SRC_HF1;
    endcase
  endfunction : legal_src

  // three-stage synchronisers; a change counts once stages two and three agree
  assign pin_raw = {low_freq_internal_osc, sosc_in_pin, osc_in_pin};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= pin_raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) lvl_r <= s3_r;
        end
      end
      assign pin_fall[g] = lvl_r && !s3_r && (s2_r == s3_r);
      assign pin_rise[g] = !lvl_r && s3_r && (s2_r == s3_r);
    end
  endgenerate

  // apb: zero wait states, error on unmapped offsets
  assign addr_ok  = (paddr == OFS_CTRL) || (paddr == OFS_STAT) ||
                    (paddr == OFS_FLAG) || (paddr == OFS_IEN);
  assign wr_acc   = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctrl  = wr_acc && (paddr == OFS_CTRL);
  assign wr_flag  = wr_acc && (paddr == OFS_FLAG);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;

  assign tgt_src  = wr_ctrl ? legal_src(pwdata[CTRL_NEW_SOURCE_SELECT_LSB +: 3]) : new_source_select_r;
  assign tgt_div  = wr_ctrl ? pwdata[CTRL_NEW_DIVIDER_SELECT_LSB +: 5] : new_divider_select_r;
  assign ctrl_chg = wr_ctrl && ({tgt_src, tgt_div} != {new_source_select_r, new_divider_select_r});
  assign do_sw    = ctrl_chg || (sleep_req && (state_r == ST_FAIL));

  // monitor and timer follow the pin of the source being used or started
  assign watch_src = (state_r == ST_START) ? new_source_select_r : src_r;
  assign ext_fall  = (watch_src == SRC_SOSC) ? pin_fall[1] : pin_fall[0];
  assign ost_done  = (state_r == ST_START) && ext_fall && (ost_cnt_r == OST_LAST);

  assign mon.lf_rise  = pin_rise[2];
  assign mon.ext_fall = ext_fall;
  assign mon.mon_en   = mon_cfg_r && cfg_done_r &&
                        (((state_r == ST_RUN) && is_ext(src_r)) || (state_r == ST_START));

  osfm_detect #(
    .SAMPLE_DIV (SAMPLE_DIV)
  ) u_detect (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (mon)
  );

  // straps are caught on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done_r    <= 1'b0;
      rst_src_r     <= SRC_RST;
      ext_mode_r    <= EXT_HIGH;
      mon_cfg_r     <= 1'b0;
      ext_power_sel <= LVL_LOW;
      xtal_gain_sel <= LVL_LOW;
      xtal_amp_en   <= 1'b0;
      osc_out_free  <= 1'b0;
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'b1;
      rst_src_r  <= legal_src(reset_osc_select);
      ext_mode_r <= ext_osc_mode_select;
      mon_cfg_r  <= monitor_config_enable;
      unique case (ext_osc_mode_select)
        EXT_LOW:  ext_power_sel <= LVL_LOW;
        EXT_MED:  ext_power_sel <= LVL_MED;
        default:  ext_power_sel <= LVL_HIGH;
      endcase
      unique case (ext_osc_mode_select)
        XTAL_LP:  xtal_gain_sel <= LVL_LOW;
        XTAL_XT:  xtal_gain_sel <= LVL_MED;
        default:  xtal_gain_sel <= LVL_HIGH;
      endcase
      xtal_amp_en  <= !is_ec(ext_osc_mode_select);
      osc_out_free <= is_ec(ext_osc_mode_select);
    end
  end

  // source state machine; nothing decays, so a stalled clock loses no state
  always_comb begin
    state_nxt = state_r;
    src_nxt   = src_r;
    div_nxt   = div_r;
    unique case (state_r)
      ST_RUN: begin
        if (mon.fail_pulse && is_ext(src_r)) begin
          state_nxt = ST_FAIL;
        end
      end
      ST_START: begin
        if (mon.fail_pulse) begin
          state_nxt = ST_FAIL;
        end else if (ost_done) begin
          state_nxt = ST_RUN;
          src_nxt   = new_source_select_r;
          div_nxt   = new_divider_select_r;
        end
      end
      ST_FAIL: begin
        state_nxt = ST_FAIL;
      end
    endcase
    if (do_sw) begin
      if (needs_ost(tgt_src, ext_mode_r)) begin
        state_nxt = ST_START;
      end else begin
        state_nxt = ST_RUN;
        src_nxt   = tgt_src;
        div_nxt   = tgt_div;
      end
    end
    if (state_nxt == ST_FAIL) begin
      src_nxt = SRC_HF1;
      div_nxt = NEW_DIVIDER_SELECT_ONE;
    end
  end

  assign fail_set = (state_nxt == ST_FAIL) && (state_r != ST_FAIL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_RUN;
      src_r      <= SRC_RST;
      div_r      <= NEW_DIVIDER_SELECT_ONE;
      hf_set_32m <= 1'b0;
    end else if (!cfg_done_r) begin
      if (needs_ost(legal_src(reset_osc_select), ext_osc_mode_select)) begin
        state_r <= ST_START;
      end else begin
        src_r      <= legal_src(reset_osc_select);
        hf_set_32m <= legal_src(reset_osc_select) == SRC_HF32;
      end
    end else begin
      state_r    <= state_nxt;
      src_r      <= src_nxt;
      div_r      <= div_nxt;
      hf_set_32m <= src_nxt == SRC_HF32;
    end
  end

  // control register holds the requested selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_source_select_r <= SRC_RST;
      new_divider_select_r <= NEW_DIVIDER_SELECT_ONE;
    end else if (!cfg_done_r) begin
      new_source_select_r <= legal_src(reset_osc_select);
    end else if (wr_ctrl) begin
      new_source_select_r <= tgt_src;
      new_divider_select_r <= tgt_div;
    end
  end

  // start-up timer counts falling edges of the oscillator being started
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt_r <= '0;
    end else if (state_nxt == ST_START && state_r != ST_START) begin
      ost_cnt_r <= '0;
    end else if (do_sw) begin
      ost_cnt_r <= '0;
    end else if ((state_r == ST_START) && ext_fall && !ost_done) begin
      ost_cnt_r <= ost_cnt_r + 1'b1;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (fail_set) begin
      flag_r <= 1'b1;
    end else if (wr_flag) begin
      flag_r <= pwdata[FLAG_FAIL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_ie_r <= 1'b0;
      glob_ie_r <= 1'b0;
    end else if (wr_acc && (paddr == OFS_IEN)) begin
      fail_ie_r <= pwdata[IEN_FAIL_BIT];
      glob_ie_r <= pwdata[IEN_GLOB_BIT];
    end
  end

  assign irq_req     = flag_r && fail_ie_r && glob_ie_r;
  assign fail_active = state_r == ST_FAIL;
  assign clk_src_sel = src_r;
  assign clk_div_sel = div_r;

  // read data is registered in the setup cycle and stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= 32'h00000000;
      unique case (paddr)
        OFS_CTRL: begin
          prdata[CTRL_NEW_DIVIDER_SELECT_LSB +: 5] <= new_divider_select_r;
          prdata[CTRL_NEW_SOURCE_SELECT_LSB +: 3] <= new_source_select_r;
        end
        OFS_STAT: begin
          prdata[STAT_SRC_LSB +: 3] <= src_r;
          prdata[STAT_DIV_LSB +: 5] <= div_r;
          prdata[STAT_FAIL_BIT]     <= state_r == ST_FAIL;
          prdata[STAT_OST_BIT]      <= state_r == ST_START;
          prdata[STAT_SAMP_BIT]     <= mon.sample_clk;
          prdata[STAT_MON_BIT]      <= mon_cfg_r;
          prdata[STAT_RST_LSB +: 3] <= rst_src_r;
          prdata[STAT_EXT_LSB +: 3] <= ext_mode_r;
        end
        OFS_FLAG: prdata[FLAG_FAIL_BIT] <= flag_r;
        OFS_IEN: begin
          prdata[IEN_FAIL_BIT] <= fail_ie_r;
          prdata[IEN_GLOB_BIT] <= glob_ie_r;
        end
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cfg_caught;
    $rose(cfg_done_r);
  endsequence
  sequence s_fail_entry;
    $rose(state_r == ST_FAIL);
  endsequence

  a_reset_source: assert property (s_cfg_caught |->
      (state_r == ST_START) || (clk_src_sel == rst_src_r))
    else $error("reset source not taken from strap");
  a_fail_hf1: assert property (s_fail_entry |->
      clk_src_sel == SRC_HF1 && clk_div_sel == NEW_DIVIDER_SELECT_ONE && flag_r)
    else $error("failure did not move to 1 MHz internal with flag");
  a_fail_holds: assert property ((state_r == ST_FAIL) && !do_sw |=>
      (state_r == ST_FAIL) && (clk_src_sel == SRC_HF1))
    else $error("left fail state without a new selection");
  a_sleep_clears: assert property (sleep_req && (state_r == ST_FAIL) |=>
      !fail_active)
    else $error("sleep did not clear fail condition");
  a_ec_bypass: assert property (ctrl_chg && !needs_ost(tgt_src, ext_mode_r) |=>
      clk_src_sel == $past(tgt_src))
    else $error("direct switch delayed");
  a_start_keeps: assert property ((state_r == ST_START) && !ost_done && !do_sw &&
      !mon.fail_pulse |=> $stable(clk_src_sel))
    else $error("source changed before timer expiry");
  a_ost_switch: assert property (ost_done && !do_sw && !mon.fail_pulse |=>
      (state_r == ST_RUN) && (clk_src_sel == $past(new_source_select_r)))
    else $error("timer expiry did not complete the switch");
  a_flag_sticky: assert property (flag_r && !(wr_flag && !pwdata[FLAG_FAIL_BIT]) |=>
      flag_r)
    else $error("fail flag dropped without a software clear");
  a_irq_gate: assert property (irq_req |-> fail_ie_r && glob_ie_r && flag_r)
    else $error("interrupt without both enables");
  a_irq_global: assert property (!glob_ie_r |-> !irq_req)
    else $error("interrupt with global enable clear");
endmodule : osfm_top
`default_nettype wire

/* File: testbench/osfm_ext_src.sv */
/*
  osfm_ext_src: logic-level external clock source for the osc input pin.
  Assumes pclk is at least eight times faster than the clock it makes.
*/
`timescale 1ns/1ns
`default_nettype none
module osfm_ext_src #(
  parameter int HALF = 4
) (
  input  wire logic pclk,
  input  wire logic run,
  output logic      clk_out
);
  int cnt;
  initial begin
    clk_out = 1'b0;
    cnt = 0;
  end
  // a dead source freezes at its last level, so no falling edge reaches the monitor
  always @(posedge pclk) begin
    if (run) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        clk_out <= ~clk_out;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : osfm_ext_src
`default_nettype wire

/* File: testbench/tb_top.sv */
/*
  tb_top: self-checking bench for osfm_top over apb.
  Assumes short start-up and sample counts; straps change only in reset, except the monitor strap, which changes one cycle before it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import osfm_pkg::*;
  localparam int OSTC = 4;
  localparam int HALF = 4;
  logic        pclk, presetn, psel, penable, pwrite, slp, run, lf, mon;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, e, osc, hf32, ofree, fail, irq, amp;
  logic [2:0]  rsel, msel, src;
  logic [4:0]  div;
  logic [1:0]  pwr, gain;
  int          n_mismatch, tests_run;
  osfm_top #(.OST_CYCLES(OSTC), .SAMPLE_DIV(4)) u_osfm_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_osc_select(rsel),
    .ext_osc_mode_select(msel), .monitor_config_enable(mon),
    .osc_in_pin(osc), .sosc_in_pin(1'b0), .low_freq_internal_osc(lf),
    .sleep_req(slp), .clk_src_sel(src), .clk_div_sel(div), .hf_set_32m(hf32),
    .ext_power_sel(pwr), .xtal_gain_sel(gain), .xtal_amp_en(amp),
    .osc_out_free(ofree), .fail_active(fail), .irq_req(irq));
  osfm_ext_src #(.HALF(HALF)) u_osfm_ext_src (.pclk(pclk), .run(run), .clk_out(osc));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // low-freq oscillator sped up to keep the run short
  initial begin
    lf = 1'b0;
    forever #400 lf = ~lf;
  end
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ends one edge after the access so register effects are visible
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic do_reset(input logic [2:0] s, input logic [2:0] m);
    @(posedge pclk);
    presetn <= 1'b0;
    rsel <= s;
    msel <= m;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset
  task automatic wait_fail(output int n);
    n = 0;
    @(posedge pclk);
    run <= 1'b0;
    while (fail !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_fail
  task automatic t_internal();
    logic [2:0] codes [3];
    codes = '{SRC_LF, SRC_HF1, SRC_HF32};
    foreach (codes[i]) begin
      do_reset(codes[i], EXT_MED);
      chk(src, codes[i]);
      chk(hf32, codes[i] == SRC_HF32);
    end
    apb(1'b0, OFS_IEN, 32'h0);
    chk(q, 32'h0);
  endtask : t_internal
  task automatic t_ec_reset();
    do_reset(SRC_EXT, EXT_MED);
    chk(src, SRC_EXT);
    chk(ofree, 1'b1);
    chk(pwr, LVL_MED);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(q[22:16], {EXT_MED, 1'b0, SRC_EXT});
    chk(q[15], 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
  endtask : t_ec_reset
  task automatic t_fail();
    int n;
    wait_fail(n);
    chk(n > 60 && n < 400, 1'b1);
    chk({src, div}, {SRC_HF1, 5'h00});
    apb(1'b0, OFS_FLAG, 32'h0);
    chk({q[0], irq}, 2'b10);
    apb(1'b1, OFS_IEN, 32'h1);
    chk(irq, 1'b0);
    apb(1'b1, OFS_IEN, 32'h3);
    chk(irq, 1'b1);
    apb(1'b1, OFS_FLAG, 32'h0);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk({q[0], irq, fail, src}, {3'b001, SRC_HF1});
    apb(1'b1, OFS_FLAG, 32'h1);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk(q[0], 1'b1);
    apb(1'b1, OFS_FLAG, 32'h0);
    run <= 1'b1;
    @(posedge pclk);
    slp <= 1'b1;
    @(posedge pclk);
    slp <= 1'b0;
    @(posedge pclk);
    chk(fail, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0203);
    chk({src, div}, {SRC_EXT, 5'h03});
  endtask : t_fail
  task automatic t_timer();
    int n;
    do_reset(SRC_HF1, XTAL_XT);
    chk({gain, amp}, {LVL_MED, 1'b1});
    apb(1'b1, OFS_CTRL, 32'h0000_0200);
    chk(src, SRC_HF1);
    n = 0;
    while (src !== SRC_EXT && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 2 * HALF * (OSTC - 2) && n < 500, 1'b1);
    wait_fail(n);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk({fail, q[0]}, 2'b11);
  endtask : t_timer
  // monitor strap off: a dead external clock must go unnoticed
  task automatic t_nomon();
    int n;
    @(posedge pclk);
    mon <= 1'b0;
    do_reset(SRC_EXT, EXT_MED);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(q[15], 1'b0);
    wait_fail(n);
    chk({fail, src}, {1'b0, SRC_EXT});
  endtask : t_nomon
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slp = 1'b0;
    run = 1'b1;
    mon = 1'b1;
    rsel = SRC_EXT;
    msel = EXT_MED;
    t_internal();
    t_ec_reset();
    t_fail();
    t_timer();
    t_nomon();
    close_out();
  end
  // whole run is a few thousand cycles
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
